// ===== rtl/pfs_pkg.sv
package pfs_pkg;

	localparam int NPIN = 20;
	localparam int AXI_AW = 32;
	localparam int AXI_DW = 32;
	localparam int IDX_W = 20;
	localparam int REG_W = 8;
	localparam int PSEL_W = 5;

	// printed offsets are word indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_GUARD = 20'h8C11F;
	localparam logic [IDX_W-1:0] IDX_P03 = 20'h8C143;
	localparam logic [IDX_W-1:0] IDX_P05 = 20'h8C145;
	localparam logic [IDX_W-1:0] IDX_P14 = 20'h8C14C;
	localparam logic [IDX_W-1:0] IDX_P15 = 20'h8C14D;
	localparam logic [IDX_W-1:0] IDX_P16 = 20'h8C14E;
	localparam logic [IDX_W-1:0] IDX_P17 = 20'h8C14F;
	localparam logic [IDX_W-1:0] IDX_P26 = 20'h8C156;
	localparam logic [IDX_W-1:0] IDX_P27 = 20'h8C157;
	localparam logic [IDX_W-1:0] IDX_P30 = 20'h8C158;
	localparam logic [IDX_W-1:0] IDX_P31 = 20'h8C159;
	localparam logic [IDX_W-1:0] IDX_P32 = 20'h8C15A;
	localparam logic [IDX_W-1:0] IDX_P35 = 20'h8C15D;
	localparam logic [IDX_W-1:0] IDX_P40 = 20'h8C160;
	localparam logic [IDX_W-1:0] IDX_P41 = 20'h8C161;
	localparam logic [IDX_W-1:0] IDX_P42 = 20'h8C162;
	localparam logic [IDX_W-1:0] IDX_P43 = 20'h8C163;
	localparam logic [IDX_W-1:0] IDX_P44 = 20'h8C164;
	localparam logic [IDX_W-1:0] IDX_P46 = 20'h8C166;
	localparam logic [IDX_W-1:0] IDX_P54 = 20'h8C16C;
	localparam logic [IDX_W-1:0] IDX_P55 = 20'h8C16D;

	localparam logic [IDX_W-1:0] PIN_IDX [NPIN] = '{IDX_P03, IDX_P05, IDX_P14, IDX_P15,
		IDX_P16, IDX_P17, IDX_P26, IDX_P27, IDX_P30, IDX_P31, IDX_P32, IDX_P35, IDX_P40,
		IDX_P41, IDX_P42, IDX_P43, IDX_P44, IDX_P46, IDX_P54, IDX_P55};

	// pin positions in the register array
	localparam int PI_P03 = 0;
	localparam int PI_P14 = 2;
	localparam int PI_P16 = 4;
	localparam int PI_P26 = 6;
	localparam int PI_P32 = 10;
	localparam int PI_P41 = 13;
	localparam int PI_P54 = 18;

	localparam int GUARD_WE_BIT = 6;
	localparam int GUARD_LOCK_BIT = 7;
	localparam logic [REG_W-1:0] GUARD_RST = 8'h80;
	localparam logic [REG_W-1:0] PIN_RST = 8'h00;
	localparam int CFG_IRQ_BIT = 6;
	localparam int CFG_ANA_BIT = 7;
	localparam logic [PSEL_W-1:0] CODE_HIZ = 5'h00;
	localparam logic [PSEL_W-1:0] CODE_RTC_P16 = 5'h07;
	localparam logic [PSEL_W-1:0] CODE_SER12_P14 = 5'h0C;

	// writable bits per register; everything else is reserved and reads zero
	localparam logic [REG_W-1:0] WMASK [NPIN] = '{8'h80, 8'h80, 8'h5F, 8'h5F, 8'h5F, 8'h5F,
		8'h1F, 8'hDF, 8'h5F, 8'h5F, 8'h5F, 8'h5F, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
		8'h1F, 8'h1F};

	// assigned select codes per pin, bit n set means code n decodes, large package
	localparam logic [31:0] LEGAL [NPIN] = '{32'h00000001, 32'h00000001, 32'h0008380F,
		32'h00002607, 32'h000EA687, 32'h0000B48F, 32'h00080403, 32'h00001683, 32'h00000483,
		32'h00000803, 32'h00000083, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
		32'h00000001, 32'h00000001, 32'h00000001, 32'h00000003, 32'h00000003};
	localparam logic [31:0] LEGAL_P32_SMALL = 32'h00000003;
	localparam logic [31:0] RTC_CODE_BIT = 32'h00000080;
	localparam logic [31:0] LEGAL_HIZ_ONLY = 32'h00000001;

	// external interrupt line per pin; NMI_LINE for the non-maskable input
	localparam int NIRQ = 8;
	localparam logic [3:0] NO_LINE = 4'hF;
	localparam logic [3:0] NMI_LINE = 4'h8;
	localparam logic [3:0] IRQ_LINE [NPIN] = '{4'hF, 4'hF, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF,
		4'h3, 4'h0, 4'h1, 4'h2, 4'h8, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};

	localparam logic [NPIN-1:0] PRESENT_64 = 20'hFFFFF;
	localparam logic [NPIN-1:0] PRESENT_48 = 20'h278FC;
	localparam logic [NPIN-1:0] PRESENT_40 = 20'h26CFC;
	localparam logic [NPIN-1:0] PRESENT_36 = 20'h068BC;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic analog;
		logic irq_sel;
		logic [PSEL_W-1:0] psel;
	} pfs_pin_cfg_t;

	typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} pfs_wstate_t;
	typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} pfs_rstate_t;

	function automatic logic [AXI_AW-1:0] byte_addr(input logic [IDX_W-1:0] idx);
		return {10'h000, idx, 2'b00};
	endfunction

	function automatic logic [NPIN-1:0] present_mask(input int pkg);
		case (pkg)
			48: return PRESENT_48;
			40: return PRESENT_40;
			36: return PRESENT_36;
			default: return PRESENT_64;
		endcase
	endfunction

	function automatic logic [31:0] legal_mask(input int pin, input int pkg);
		logic [31:0] m;
		logic [NPIN-1:0] pm;
		m = LEGAL[pin];
		pm = present_mask(pkg);
		if (pin == PI_P16 && pkg < 48) begin
			m = m & ~RTC_CODE_BIT;
		end
		if (pin == PI_P32 && pkg == 40) begin
			m = LEGAL_P32_SMALL;
		end
		if (!pm[pin]) begin
			m = LEGAL_HIZ_ONLY;
		end
		return m;
	endfunction

endpackage

// ===== rtl/pfs_pin_function_regs.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
// What this block and its software do
// R1 - function registers writable only while enable set
// R2 - enable bit changes only while lock clear
// R3 - software clears lock, then sets enable
// R4 - guard: enable bit 6, lock bit 7
// R5 - 5-bit select field; zero means high-impedance
// R6 - interrupt select routes pin to its line
// R7 - software avoids one line on two pins
// R8 - analog select bit 7 switches pin analog
// R9 - software sets port input before analog
// R10 - analog pins hide digital pin state
// R11 - reserved bits read zero, written zero
// R12 - absent-pin bits reserved, keep reset value
// R13 - select bits without function are reserved
// R14 - software never writes unassigned select codes
// R15 - port 1 pins decode listed codes, lines 4-7
// R16 - small packages: no rtc output on pin 6
// R17 - port 2 pins 6, 7 decode listed codes
// R18 - port 3 interrupt lines and select codes
// R19 - 40-pin port 3: pin 2 timer only
// R20 - port 4 pins: analog bit only
// R21 - port 0 pins 3, 5: dac analog only
// R22 - port 5 pins 4, 5: select field only
// R23 - protected writes dropped silently, okay response
// R24 - software gives each signal one pin
module pfs_pin_function_regs #(
	parameter int PKG_PINS = 64
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_sys_rst, // synchronous reset, active high
	input wire logic [pfs_pkg::AXI_AW-1:0] i_awaddr, // write address
	input wire logic i_awvalid, // write address valid
	output logic o_awready, // write address ready
	input wire logic [pfs_pkg::AXI_DW-1:0] i_wdata, // write data
	input wire logic [3:0] i_wstrb, // write byte strobes
	input wire logic i_wvalid, // write data valid
	output logic o_wready, // write data ready
	output logic [1:0] o_bresp, // write response
	output logic o_bvalid, // write response valid
	input wire logic i_bready, // write response ready
	input wire logic [pfs_pkg::AXI_AW-1:0] i_araddr, // read address
	input wire logic i_arvalid, // read address valid
	output logic o_arready, // read address ready
	output logic [pfs_pkg::AXI_DW-1:0] o_rdata, // read data
	output logic [1:0] o_rresp, // read response
	output logic o_rvalid, // read data valid
	input wire logic i_rready, // read data ready
	input wire logic [pfs_pkg::NPIN-1:0] i_pin_level, // raw pin levels
	output pfs_pkg::pfs_pin_cfg_t o_pin_cfg [pfs_pkg::NPIN], // per-pin routing
	output logic [pfs_pkg::NPIN-1:0] o_code_legal, // select code assigned
	output logic [pfs_pkg::NPIN-1:0] o_pin_state, // readable digital state
	output logic [pfs_pkg::NIRQ-1:0] o_ext_irq, // external interrupt lines
	output logic o_nmi, // non-maskable interrupt input
	output logic o_write_enabled // function writes open
);
	import pfs_pkg::*;

	localparam logic [NPIN-1:0] PRESENT = present_mask(PKG_PINS);

	pfs_wstate_t wst, next_wst;
	pfs_rstate_t rst_q, next_rst;
	logic next_awready, next_wready, next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready, next_rvalid;
	logic [AXI_DW-1:0] next_rdata;
	logic [1:0] next_rresp;
	logic wr_fire, wr_guard, wr_hit;
	logic rd_guard, rd_hit;
	logic [NPIN-1:0] wr_sel, rd_sel;
	logic guard_we, guard_lock, next_we, next_lock;
	logic [REG_W-1:0] pin_reg [NPIN];
	logic [REG_W*NPIN-1:0] pin_flat;
	logic [REG_W-1:0] rd_byte;
	logic [NPIN-1:0] sync1, sync2;
	logic [NPIN-1:0] next_pin_state, next_legal;
	logic [NIRQ-1:0] next_irq;
	logic next_nmi;

	// address decode, two comparators per pin register, one per channel
	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_pin
			logic [REG_W-1:0] next_pin;
			logic [31:0] legal;
			assign wr_sel[g] = (i_awaddr == byte_addr(PIN_IDX[g]));
			assign rd_sel[g] = (i_araddr == byte_addr(PIN_IDX[g]));
			assign legal = legal_mask(g, PKG_PINS); // see R15 see R16 see R17 see R19
			assign pin_flat[g*REG_W +: REG_W] = pin_reg[g];

			always_comb begin
				next_pin = pin_reg[g];
				// dropped write answers okay but stores nothing: see R23
				if (wr_fire && wr_sel[g] && i_wstrb[0] && guard_we) begin // see R1
					// reserved and absent bits stay zero: see R11 see R12 see R13
					next_pin = PRESENT[g] ? (i_wdata[REG_W-1:0] & WMASK[g]) : PIN_RST;
				end
			end

			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					pin_reg[g] <= PIN_RST; // see R5 see R20
				end else begin
					pin_reg[g] <= next_pin;
				end
			end

			// bit positions fixed per pin: see R8 see R20 see R21 see R22
			assign o_pin_cfg[g].analog = pin_reg[g][CFG_ANA_BIT];
			assign o_pin_cfg[g].irq_sel = pin_reg[g][CFG_IRQ_BIT];
			assign o_pin_cfg[g].psel = pin_reg[g][PSEL_W-1:0]; // see R5
			assign next_legal[g] = legal[pin_reg[g][PSEL_W-1:0]]; // see R18 see R22
			// analog pins read back as zero: see R10
			assign next_pin_state[g] = sync2[g] & ~pin_reg[g][CFG_ANA_BIT];
		end
	endgenerate

	assign wr_guard = (i_awaddr == byte_addr(IDX_GUARD));
	assign rd_guard = (i_araddr == byte_addr(IDX_GUARD));
	assign wr_hit = wr_guard | (|wr_sel);
	assign rd_hit = rd_guard | (|rd_sel);

	// write channel: address and data taken together, one outstanding
	always_comb begin
		next_wst = wst;
		next_awready = 1'b0;
		next_wready = 1'b0;
		next_bvalid = o_bvalid;
		next_bresp = o_bresp;
		wr_fire = 1'b0;
		case (wst)
			WS_IDLE: begin
				if (o_awready) begin
					wr_fire = 1'b1;
					next_bvalid = 1'b1;
					next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR; // see R23
					next_wst = WS_RESP;
				end else if (i_awvalid && i_wvalid) begin
					next_awready = 1'b1;
					next_wready = 1'b1;
				end
			end
			WS_RESP: begin
				if (i_bready) begin
					next_bvalid = 1'b0;
					next_wst = WS_IDLE;
				end
			end
			default: begin
				next_wst = WS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wst <= WS_IDLE;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end else begin
			wst <= next_wst;
			o_awready <= next_awready;
			o_wready <= next_wready;
			o_bvalid <= next_bvalid;
			o_bresp <= next_bresp;
		end
	end

	// guard register: lock is sampled before this write, so a single
	// write cannot both unlock and open the gate
	always_comb begin
		next_we = guard_we;
		next_lock = guard_lock;
		if (wr_fire && wr_guard && i_wstrb[0]) begin
			next_lock = i_wdata[GUARD_LOCK_BIT];
			if (!guard_lock) begin // see R2 see R3
				next_we = i_wdata[GUARD_WE_BIT];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			guard_we <= GUARD_RST[GUARD_WE_BIT];
			guard_lock <= GUARD_RST[GUARD_LOCK_BIT];
			o_write_enabled <= GUARD_RST[GUARD_WE_BIT];
		end else begin
			guard_we <= next_we;
			guard_lock <= next_lock;
			o_write_enabled <= next_we;
		end
	end

	// read data mux; upper bits and reserved bits are zero
	always_comb begin
		rd_byte = '0;
		if (rd_guard) begin
			rd_byte[GUARD_WE_BIT] = guard_we; // see R4
			rd_byte[GUARD_LOCK_BIT] = guard_lock; // see R4
		end
		for (int i = 0; i < NPIN; i++) begin
			if (rd_sel[i]) begin
				rd_byte = pin_reg[i]; // see R11
			end
		end
	end

	always_comb begin
		next_rst = rst_q;
		next_arready = 1'b0;
		next_rvalid = o_rvalid;
		next_rdata = o_rdata;
		next_rresp = o_rresp;
		case (rst_q)
			RS_IDLE: begin
				if (o_arready) begin
					next_rvalid = 1'b1;
					next_rdata = {{(AXI_DW-REG_W){1'b0}}, rd_byte};
					next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
					next_rst = RS_DATA;
				end else if (i_arvalid) begin
					next_arready = 1'b1;
				end
			end
			RS_DATA: begin
				if (i_rready) begin
					next_rvalid = 1'b0;
					next_rst = RS_IDLE;
				end
			end
			default: begin
				next_rst = RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			rst_q <= RS_IDLE;
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= RESP_OKAY;
		end else begin
			rst_q <= next_rst;
			o_arready <= next_arready;
			o_rvalid <= next_rvalid;
			o_rdata <= next_rdata;
			o_rresp <= next_rresp;
		end
	end

	// interrupt routing works alongside the selected peripheral
	always_comb begin
		next_irq = '0;
		next_nmi = 1'b0;
		for (int i = 0; i < NPIN; i++) begin
			if (pin_reg[i][CFG_IRQ_BIT] && IRQ_LINE[i] != NO_LINE) begin // see R6 see R13
				if (IRQ_LINE[i] == NMI_LINE) begin
					next_nmi = next_nmi | sync2[i]; // see R18
				end else begin
					next_irq[IRQ_LINE[i][2:0]] = next_irq[IRQ_LINE[i][2:0]] | sync2[i];
				end
			end
		end
	end

	// pin levels are asynchronous; only sync2 feeds logic
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sync1 <= '0;
			sync2 <= '0;
			o_pin_state <= '0;
			o_code_legal <= '1;
			o_ext_irq <= '0;
			o_nmi <= 1'b0;
		end else begin
			sync1 <= i_pin_level;
			sync2 <= sync1;
			o_pin_state <= next_pin_state;
			o_code_legal <= next_legal;
			o_ext_irq <= next_irq;
			o_nmi <= next_nmi;
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);

	AST_PROT_DISCARD: assert property ( // see R1
		(wr_fire && !guard_we) |=> $stable(pin_flat))
		else $error("function register changed while writes closed");
	AST_LOCK_HOLDS: assert property ( // see R2
		(wr_fire && wr_guard && guard_lock) |=> (guard_we == $past(guard_we)))
		else $error("enable bit changed while locked");
	AST_UNLOCK_SET: assert property ( // see R3
		(wr_fire && wr_guard && i_wstrb[0] && !guard_lock)
		|=> (guard_we == $past(i_wdata[GUARD_WE_BIT])) ##1 (o_write_enabled == guard_we))
		else $error("enable bit did not follow unlocked write");
	AST_GUARD_READ: assert property ( // see R4
		(o_arready && rd_guard) |=> (o_rvalid && o_rdata[5:0] == 6'h00
		&& o_rdata[GUARD_WE_BIT] == $past(guard_we)))
		else $error("guard read back wrong");
	AST_RSVD_ZERO: assert property ( // see R11
		o_rvalid |-> (o_rdata[AXI_DW-1:REG_W] == 24'h000000))
		else $error("upper read bits not zero");
	AST_IRQ_ROUTE: assert property ( // see R6
		(pin_reg[PI_P14][CFG_IRQ_BIT] && sync2[PI_P14]) |=> o_ext_irq[4])
		else $error("pin 1.4 interrupt not routed to line 4");
	AST_ANALOG_HIDE: assert property ( // see R10
		$past(pin_reg[PI_P41][CFG_ANA_BIT]) |-> !o_pin_state[PI_P41])
		else $error("analog pin state visible");
	AST_NO_LINE_BITS: assert property ( // see R13
		pin_reg[PI_P26][7:5] == 3'b000)
		else $error("reserved select bits set on pin 2.6");
	AST_P5_FIELD: assert property ( // see R22
		pin_reg[PI_P54][7:5] == 3'b000)
		else $error("reserved bits set on pin 5.4");
	// absent pin keeps reset value; present pin holds only writable bits
	AST_ABSENT_PIN: assert property ( // see R12
		(pin_reg[PI_P03] & ~(PRESENT[PI_P03] ? WMASK[PI_P03] : PIN_RST)) == PIN_RST)
		else $error("absent or reserved bits of pin 0.3 left their reset value");
	AST_CODE_DECODE: assert property ( // see R15
		(pin_reg[PI_P14][PSEL_W-1:0] == CODE_SER12_P14) |=> o_code_legal[PI_P14])
		else $error("assigned code on pin 1.4 not decoded");
	AST_SMALL_RTC: assert property ( // see R16
		(pin_reg[PI_P16][PSEL_W-1:0] == CODE_RTC_P16)
		|=> (o_code_legal[PI_P16] == (PKG_PINS >= 48)))
		else $error("rtc code decode on pin 1.6 wrong for package");
	AST_WRITE_ANSWER: assert property ( // see R23
		(i_awvalid && i_wvalid && wst == WS_IDLE && !o_awready)
		|=> o_awready ##1 (o_bvalid && (o_bresp == RESP_OKAY || !$past(wr_hit))))
		else $error("write not answered in two cycles");

	COV_UNLOCK: cover property (wr_fire && wr_guard && !guard_lock && i_wdata[GUARD_WE_BIT]);
	COV_DISCARD: cover property (wr_fire && !guard_we && (|wr_sel));
	COV_ANALOG: cover property (o_pin_cfg[PI_P41].analog && sync2[PI_P41]);
	COV_IRQ: cover property (o_ext_irq[4]);
endmodule

// ===== verif/pfs_pin_model.sv
`timescale 1ns/1ns
// far side: package pins whose levels the bench chooses
module pfs_pin_model (
	input wire logic i_clk_sys, // system clock
	input wire logic [pfs_pkg::NPIN-1:0] i_want, // levels the bench asks for
	output logic [pfs_pkg::NPIN-1:0] o_pin_level // levels seen by the device
);
	import pfs_pkg::*;
	// pins move one edge after the request, like a slow external source
	initial begin
		o_pin_level = '0;
	end
	always @(posedge i_clk_sys) begin
		o_pin_level <= i_want;
	end
endmodule

// ===== verif/pfs_pin_function_regs_tb.sv
`timescale 1ns/1ns
module pfs_pin_function_regs_tb;
	import pfs_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, wr_en, nmi;
	logic [1:0] bresp, rresp;
	logic [NPIN-1:0] want = '0, pin_level, code_legal, pin_state;
	logic [NIRQ-1:0] ext_irq;
	pfs_pin_cfg_t pin_cfg [NPIN];
	int num_errors = 0, n_tests = 0;

	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	pfs_pin_model u_pfs_pin_model (.i_clk_sys(clk_sys), .i_want(want), .o_pin_level(pin_level));

	pfs_pin_function_regs #(.PKG_PINS(64)) u_pfs_pin_function_regs (
		.i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_pin_level(pin_level), .o_pin_cfg(pin_cfg), .o_code_legal(code_legal),
		.o_pin_state(pin_state), .o_ext_irq(ext_irq), .o_nmi(nmi), .o_write_enabled(wr_en)
	);

	function automatic logic [31:0] addr_of(input logic [IDX_W-1:0] idx);
		return {10'h000, idx, 2'b00};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// a missing answer leaves the response at 3, which no compare accepts
	task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
		r = 2'h3;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		repeat (40) begin
			@(posedge clk_sys);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		d = 32'hFFFFFFFF;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (40) begin
			@(posedge clk_sys);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				r = rresp;
				d = rdata;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic wr_ok(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(addr_of(idx), d, r);
		chk({30'h0, r}, RESP_OKAY, "write resp");
	endtask

	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
		logic [1:0] r;
		logic [31:0] d;
		axi_rd(addr_of(idx), d, r);
		chk({30'h0, r}, RESP_OKAY, "read resp");
		chk(d, {24'h000000, exp}, "read data");
	endtask

	task automatic t_reset();
		rd_chk(IDX_GUARD, 8'h80);
		rd_chk(IDX_P41, 8'h00);
		chk(wr_en, 1'b0, "enable after reset");
	endtask

	task automatic t_guard();
		wr_ok(IDX_P14, 8'h01);
		rd_chk(IDX_P14, 8'h00);
		wr_ok(IDX_GUARD, 8'hC0);
		rd_chk(IDX_GUARD, 8'h80);
		// clearing lock and setting enable in one write must not open the gate
		wr_ok(IDX_GUARD, 8'h40);
		rd_chk(IDX_GUARD, 8'h00);
		chk(wr_en, 1'b0, "gate still closed");
		wr_ok(IDX_GUARD, 8'h00);
		wr_ok(IDX_GUARD, 8'h7F);
		rd_chk(IDX_GUARD, 8'h40);
		chk(wr_en, 1'b1, "enable open");
	endtask

	task automatic t_reserved();
		int p [7] = '{0, 2, 6, 7, 11, 13, 18};
		logic [7:0] e [7] = '{8'h80, 8'h5F, 8'h1F, 8'hDF, 8'h5F, 8'h80, 8'h1F};
		for (int i = 0; i < 7; i++) begin
			wr_ok(PIN_IDX[p[i]], 8'hFF);
			rd_chk(PIN_IDX[p[i]], e[i]);
		end
	endtask

	task automatic t_codes();
		int p [10] = '{2, 2, 2, 4, 6, 6, 7, 10, 18, 18};
		logic [4:0] c [10] = '{5'h0C, 5'h04, 5'h00, 5'h07, 5'h13, 5'h07, 5'h09, 5'h07, 5'h01, 5'h02};
		logic l [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 10; i++) begin
			wr_ok(PIN_IDX[p[i]], {3'h0, c[i]});
			repeat (2) @(posedge clk_sys);
			chk(code_legal[p[i]], l[i], "code legal");
			chk(pin_cfg[p[i]].psel, c[i], "select field");
		end
	endtask

	task automatic t_irq();
		// one line per pin and one pin per signal; assigned codes only
		wr_ok(PIN_IDX[2], 8'h4C);
		wr_ok(PIN_IDX[11], 8'h40);
		@(posedge clk_sys);
		want[2] <= 1'b1;
		want[11] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(ext_irq, 8'h10, "irq line 4");
		chk(nmi, 1'b1, "nmi");
		chk(pin_cfg[2].psel, 5'h0C, "function kept");
		chk(pin_cfg[2].irq_sel, 1'b1, "irq select");
		want <= '0;
		repeat (5) @(posedge clk_sys);
		chk(ext_irq, 8'h00, "irq idle");
		chk(nmi, 1'b0, "nmi idle");
	endtask

	task automatic t_analog();
		wr_ok(PIN_IDX[13], 8'h00);
		@(posedge clk_sys);
		want[13] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(pin_state[13], 1'b1, "digital state");
		wr_ok(PIN_IDX[13], 8'h80);
		repeat (3) @(posedge clk_sys);
		chk(pin_state[13], 1'b0, "analog hides state");
		chk(pin_cfg[13].analog, 1'b1, "analog select");
	endtask

	task automatic t_unmapped();
		logic [1:0] r;
		logic [31:0] d;
		axi_rd(addr_of(20'h8C120), d, r);
		chk({30'h0, r}, RESP_SLVERR, "unmapped read");
		chk(d, 32'h00000000, "unmapped data");
		axi_wr(addr_of(20'h8C120), 8'hFF, r);
		chk({30'h0, r}, RESP_SLVERR, "unmapped write");
	endtask

	task automatic t_relock();
		wr_ok(IDX_GUARD, 8'h80);
		rd_chk(IDX_GUARD, 8'h80);
		chk(wr_en, 1'b0, "enable closed");
		wr_ok(PIN_IDX[13], 8'h00);
		rd_chk(PIN_IDX[13], 8'h80);
	endtask

	task automatic conclude();
		$display("errors %0d, comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// whole sequence needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_guard();
		t_reserved();
		t_codes();
		t_irq();
		t_analog();
		t_unmapped();
		t_relock();
		conclude();
	end
endmodule
